// ===== fes_event_status.sv
`timescale 1ns/1ps
module fes_event_status
	import fes_pkg::*;
#(
	parameter int SCALED_TICKS = FES_SCALED_TICKS
)(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	output logic      [7:0] cpu_rdata_r,
	output logic            int_n_r,
	input  wire logic       e1_mode,
	input  wire logic       esf_mode,
	input  wire logic       crc4_en,
	input  wire logic [2:0] ssm_sa_sel,
	input  wire logic [3:0] tx_ssm_code,
	input  wire logic       rx_frame_tick,
	input  wire logic       rx_crc_mf_sync,
	input  wire logic [7:0] rx_ts16_byte,
	input  wire logic [4:0] rx_sa_bits,
	input  wire logic       tx_frame_tick,
	input  wire logic       rx_link_strobe,
	input  wire logic       rx_link_bit,
	input  wire logic       tx_link_strobe,
	input  wire logic       rx_alarm_ci_detect,
	input  wire logic       tx_clk_pin,
	output logic            tx_link_bit_r,
	output logic      [4:0] tx_sa_bits_r,
	output logic      [3:0] rx_ssm_code_r,
	output logic            rx_ssm_valid_r
);

	// ------------------------------------------------------------
	// Registers and event vectors
	// ------------------------------------------------------------
	logic [7:0] link_status_r;
	logic [7:0] link_mask_r;
	logic [6:0] frame_status_r;
	logic [7:0] frame_mask_r;
	logic [7:0] tx_link_byte_r;
	logic [7:0] rx_link_byte_r;
	logic [7:0] match1_r;
	logic [7:0] match2_r;
	logic [7:0] link_set;
	logic [6:0] frame_set;
	logic [7:0] link_clr;
	logic [6:0] frame_clr;

	// ------------------------------------------------------------
	// Frame timing
	// ------------------------------------------------------------
	logic [4:0] mf_frames;
	logic [4:0] rx_idx;
	logic [4:0] tx_idx;
	logic       rx_fs;
	logic       rx_mfs;
	logic       tx_fs;
	logic       tx_mfs;

	// T1 multiframe lengths give 1.5ms (D4) or 3ms (ESF) at 125us frames
	assign mf_frames = e1_mode ? FES_E1_MF_FRAMES :
		(esf_mode ? FES_ESF_MF_FRAMES : FES_D4_MF_FRAMES);

	// CRC4 boundary realigns the count; without CRC4 it free-runs
	fes_frame_counter #(.W(5)) u_rx_cnt (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.tick          (rx_frame_tick),
		.resync        (e1_mode && crc4_en && rx_crc_mf_sync),
		.frames        (mf_frames),
		.idx_r         (rx_idx),
		.frame_start_r (rx_fs),
		.mf_start_r    (rx_mfs)
	);

	fes_frame_counter #(.W(5)) u_tx_cnt (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.tick          (tx_frame_tick),
		.resync        (1'b0),
		.frames        (mf_frames),
		.idx_r         (tx_idx),
		.frame_start_r (tx_fs),
		.mf_start_r    (tx_mfs)
	);

	// ------------------------------------------------------------
	// Slot 16 signaling monitors and quality message receive
	// ------------------------------------------------------------
	logic       sig_any_one_r;
	logic [4:0] sig_zero_cnt_r;
	logic [2:0] ssm_sh_r;
	logic [3:0] ssm_last_r;
	logic [1:0] ssm_alike_r;
	logic       sig_zero_hit;
	logic       sig_ones_hit;
	logic       rx_sa_bit;
	logic [4:0] zeros_now;
	logic       rx_end_mf;
	logic       rx_end_sub;

	function automatic logic [4:0] count_zeros(input logic [7:0] b);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < 8; i++)
			n = n + 5'(!b[i]);
		return n;
	endfunction : count_zeros

	assign zeros_now    = count_zeros(rx_ts16_byte);
	assign rx_end_mf    = rx_frame_tick && (rx_idx[3:0] == FES_SUBMF_LAST_B);
	assign rx_end_sub   = rx_frame_tick && rx_idx[0] &&
		((rx_idx[3:0] == FES_SUBMF_LAST_A) || (rx_idx[3:0] == FES_SUBMF_LAST_B));
	assign sig_zero_hit = e1_mode && rx_end_mf && !sig_any_one_r &&
		(rx_ts16_byte == 8'h00);
	// Not gated by any CCS setting
	assign sig_ones_hit = e1_mode && rx_end_mf &&
		((sig_zero_cnt_r + zeros_now) < 5'(FES_SIG_ZERO_MIN));
	assign rx_sa_bit    = rx_sa_bits[ssm_sa_sel];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sig_any_one_r  <= 1'b0;
			sig_zero_cnt_r <= '0;
		end
		else if (rx_frame_tick)
		begin
			if (rx_end_mf)
			begin
				sig_any_one_r  <= 1'b0;
				sig_zero_cnt_r <= '0;
			end
			else
			begin
				sig_any_one_r  <= sig_any_one_r | (|rx_ts16_byte);
				if (sig_zero_cnt_r < 5'(FES_SIG_ZERO_MIN))
					sig_zero_cnt_r <= sig_zero_cnt_r + zeros_now;
			end
		end
	end

	// Sa bits of odd frames 1,3,5,7 carry one message, MSB first
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssm_sh_r       <= '0;
			ssm_last_r     <= FES_SSM_UNKNOWN;
			ssm_alike_r    <= '0;
			rx_ssm_code_r  <= FES_SSM_UNKNOWN;
			rx_ssm_valid_r <= 1'b0;
		end
		else if (e1_mode && rx_frame_tick && rx_idx[0])
		begin
			ssm_sh_r <= {ssm_sh_r[1:0], rx_sa_bit};
			if (rx_end_sub)
			begin
				ssm_last_r <= {ssm_sh_r, rx_sa_bit};
				if ({ssm_sh_r, rx_sa_bit} != ssm_last_r)
					ssm_alike_r <= 2'd1;
				else if (ssm_alike_r != FES_SSM_ALIKE)
					ssm_alike_r <= ssm_alike_r + 2'd1;
				if (({ssm_sh_r, rx_sa_bit} == ssm_last_r) &&
					(ssm_alike_r == FES_SSM_ALIKE - 2'd1))
				begin
					rx_ssm_code_r  <= ssm_last_r;
					rx_ssm_valid_r <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Quality message transmit
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_sa_bits_r <= 5'h1f;
		else if (tx_fs)
		begin
			tx_sa_bits_r <= 5'h1f;
			if (e1_mode && tx_idx[0])
				tx_sa_bits_r[ssm_sa_sel] <= tx_ssm_code[2'd3 - tx_idx[2:1]];
		end
	end

	// ------------------------------------------------------------
	// Receive data link: abort, clear, code detect, byte assembly
	// ------------------------------------------------------------
	logic [3:0]  ones_cnt_r;
	logic [4:0]  clear_cnt_r;
	logic [15:0] code_win_r;
	logic [5:0]  rx_code_r;
	logic [7:0]  rx_sh_r;
	logic [2:0]  rx_bits_r;
	logic [15:0] code_win_nxt;
	logic        abort_hit;
	logic        clear_hit;
	logic        code_hit;
	logic        full_hit;
	logic [7:0]  rx_byte_nxt;

	assign code_win_nxt = {rx_link_bit, code_win_r[15:1]};
	assign rx_byte_nxt  = {rx_link_bit, rx_sh_r[7:1]};
	assign abort_hit    = rx_link_strobe && rx_link_bit &&
		(ones_cnt_r == FES_ABORT_ONES - 4'd1);
	assign clear_hit    = rx_link_strobe && !abort_hit &&
		(clear_cnt_r == FES_CLEAR_BITS - 5'd1);
	// Flag of eight ones, then 0, six code bits, 0
	assign code_hit     = rx_link_strobe && (code_win_nxt[7:0] == 8'hff) &&
		!code_win_nxt[8] && !code_win_nxt[15] &&
		(code_win_nxt[14:9] != rx_code_r);
	assign full_hit     = rx_link_strobe && (rx_bits_r == 3'd7);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ones_cnt_r  <= '0;
			clear_cnt_r <= '0;
		end
		else if (rx_link_strobe)
		begin
			if (!rx_link_bit)
				ones_cnt_r <= '0;
			else if (ones_cnt_r != FES_ABORT_ONES)
				ones_cnt_r <= ones_cnt_r + 4'd1;
			// Saturates so the event fires once per quiet stretch
			if (abort_hit)
				clear_cnt_r <= '0;
			else if (clear_cnt_r != FES_CLEAR_BITS)
				clear_cnt_r <= clear_cnt_r + 5'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_win_r     <= '0;
			rx_code_r      <= FES_CODE_RESET;
			rx_sh_r        <= '0;
			rx_bits_r      <= '0;
			rx_link_byte_r <= FES_REG_RESET;
		end
		else if (rx_link_strobe)
		begin
			code_win_r <= code_win_nxt;
			rx_sh_r    <= rx_byte_nxt;
			rx_bits_r  <= rx_bits_r + 3'd1;
			if (code_hit)
				rx_code_r <= code_win_nxt[14:9];
			if (full_hit)
				rx_link_byte_r <= rx_byte_nxt;
		end
	end

	// ------------------------------------------------------------
	// Transmit data link byte, also the D4 Fs source
	// ------------------------------------------------------------
	logic [6:0] tx_sh_r;
	logic [2:0] tx_bits_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sh_r       <= '0;
			tx_bits_r     <= '0;
			tx_link_bit_r <= 1'b0;
		end
		else if (tx_link_strobe)
		begin
			tx_bits_r <= tx_bits_r + 3'd1;
			if (tx_bits_r == 3'd0)
			begin
				tx_link_bit_r <= tx_link_byte_r[0];
				tx_sh_r       <= tx_link_byte_r[7:1];
			end
			else
			begin
				tx_link_bit_r <= tx_sh_r[0];
				tx_sh_r       <= {1'b0, tx_sh_r[6:1]};
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit clock loss watchdog
	// ------------------------------------------------------------
	logic [2:0]  tclk_sync_r;
	logic        tclk_level_r;
	logic [15:0] div_cnt_r;
	logic        div_en;
	logic [3:0]  loss_cnt_r;
	logic        tclk_toggle;
	logic        loss_hit;

	assign tclk_toggle = (tclk_sync_r[1] == tclk_sync_r[2]) &&
		(tclk_sync_r[2] != tclk_level_r);
	assign div_en      = (div_cnt_r == 16'(SCALED_TICKS - 1));
	assign loss_hit    = div_en && !tclk_toggle &&
		(loss_cnt_r == FES_LOSS_PERIODS - 4'd1);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tclk_sync_r  <= '0;
			tclk_level_r <= 1'b0;
			div_cnt_r    <= '0;
			loss_cnt_r   <= '0;
		end
		else
		begin
			tclk_sync_r <= {tclk_sync_r[1:0], tx_clk_pin};
			if (tclk_toggle)
				tclk_level_r <= tclk_sync_r[2];
			div_cnt_r <= div_en ? 16'h0000 : div_cnt_r + 16'h0001;
			if (tclk_toggle)
				loss_cnt_r <= '0;
			else if (div_en && (loss_cnt_r != FES_LOSS_PERIODS))
				loss_cnt_r <= loss_cnt_r + 4'd1;
		end
	end

	// ------------------------------------------------------------
	// Event collection
	// ------------------------------------------------------------
	logic tx_empty_hit;
	logic match_hit;

	assign tx_empty_hit = tx_link_strobe && (tx_bits_r == 3'd7);
	assign match_hit    = full_hit && ((rx_byte_nxt == match1_r) ||
		(rx_byte_nxt == match2_r));

	always_comb
	begin
		link_set                    = '0;
		link_set[FES_B_CODE_CHANGE] = code_hit;
		link_set[FES_B_MATCH]       = match_hit;
		link_set[FES_B_TX_EMPTY]    = tx_empty_hit;
		link_set[FES_B_RX_FULL]     = full_hit;
		link_set[FES_B_ABORT]       = abort_hit;
		link_set[FES_B_CODE_CLEAR]  = clear_hit;
		link_set[FES_B_CLK_LOSS]    = loss_hit;
		link_set[FES_B_ALARM_CI]    = rx_alarm_ci_detect && !e1_mode;
	end

	always_comb
	begin
		frame_set                 = '0;
		frame_set[FES_B_RX_ALIGN] = e1_mode && rx_fs && !rx_idx[0];
		frame_set[FES_B_RX_CRCMF] = e1_mode && rx_mfs;
		frame_set[FES_B_RX_MF]    = rx_mfs;
		frame_set[FES_B_TX_ALIGN] = e1_mode && tx_fs && !tx_idx[0];
		frame_set[FES_B_TX_MF]    = tx_mfs;
		frame_set[FES_B_SIG_ZERO] = sig_zero_hit;
		frame_set[FES_B_SIG_ONES] = sig_ones_hit;
	end

	// ------------------------------------------------------------
	// Host register access
	// ------------------------------------------------------------
	assign link_clr  = (cpu_wr && cpu_addr == FES_LINK_STATUS_ADDR) ? cpu_wdata : 8'h00;
	assign frame_clr = (cpu_wr && cpu_addr == FES_FRAME_STATUS_ADDR) ? cpu_wdata[6:0] : 7'h00;

	// Set wins over a clear in the same cycle, so no event is lost
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_status_r  <= FES_REG_RESET;
			frame_status_r <= FES_REG_RESET[6:0];
		end
		else
		begin
			link_status_r  <= (link_status_r & ~link_clr) | link_set;
			frame_status_r <= (frame_status_r & ~frame_clr) | frame_set;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_mask_r    <= FES_REG_RESET;
			frame_mask_r   <= FES_REG_RESET;
			tx_link_byte_r <= FES_REG_RESET;
			match1_r       <= FES_REG_RESET;
			match2_r       <= FES_REG_RESET;
		end
		else if (cpu_wr)
		begin
			case (cpu_addr)
				FES_LINK_MASK_ADDR:    link_mask_r    <= cpu_wdata;
				FES_FRAME_MASK_ADDR:   frame_mask_r   <= cpu_wdata;
				FES_TX_LINK_BYTE_ADDR: tx_link_byte_r <= cpu_wdata;
				FES_MATCH1_ADDR:       match1_r       <= cpu_wdata;
				FES_MATCH2_ADDR:       match2_r       <= cpu_wdata;
				default:               ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cpu_rdata_r <= 8'h00;
		else if (cpu_rd)
		begin
			case (cpu_addr)
				FES_LINK_STATUS_ADDR:  cpu_rdata_r <= link_status_r;
				FES_LINK_MASK_ADDR:    cpu_rdata_r <= link_mask_r;
				FES_FRAME_STATUS_ADDR: cpu_rdata_r <= {1'b0, frame_status_r};
				FES_FRAME_MASK_ADDR:   cpu_rdata_r <= frame_mask_r;
				FES_RX_LINK_BYTE_ADDR: cpu_rdata_r <= rx_link_byte_r;
				FES_TX_LINK_BYTE_ADDR: cpu_rdata_r <= tx_link_byte_r;
				FES_MATCH1_ADDR:       cpu_rdata_r <= match1_r;
				FES_MATCH2_ADDR:       cpu_rdata_r <= match2_r;
				default:               cpu_rdata_r <= 8'h00;
			endcase
		end
	end

	// Mask bit 7 of the frame mask has no event behind it and is ignored
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			int_n_r <= 1'b1;
		else
			int_n_r <= !((|(link_status_r & link_mask_r)) ||
				(|(frame_status_r & frame_mask_r[6:0])));
	end

endmodule : fes_event_status

// ===== fes_event_status_assertions.sv
`timescale 1ns/1ps
module fes_event_status_assertions
	import fes_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic       cpu_wr,
	input wire logic       cpu_rd,
	input wire logic [7:0] cpu_rdata_r,
	input wire logic       int_n_r,
	input wire logic       tx_frame_tick,
	input wire logic       tx_link_strobe,
	input wire logic       tx_link_bit_r,
	input wire logic [4:0] tx_sa_bits_r,
	input wire logic [3:0] rx_ssm_code_r,
	input wire logic       rx_ssm_valid_r
);
	// ------------------------------------------------------------
	// Shadow copies of host-written registers
	// ------------------------------------------------------------
	logic [7:0] link_m_r, frame_m_r, tx_byte_r, tx_cur_r;
	logic [2:0] tx_cnt_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_m_r  <= FES_REG_RESET;
			frame_m_r <= FES_REG_RESET;
			tx_byte_r <= FES_REG_RESET;
		end
		else if (cpu_wr && cpu_addr == FES_LINK_MASK_ADDR)
			link_m_r <= cpu_wdata;
		else if (cpu_wr && cpu_addr == FES_FRAME_MASK_ADDR)
			frame_m_r <= cpu_wdata;
		else if (cpu_wr && cpu_addr == FES_TX_LINK_BYTE_ADDR)
			tx_byte_r <= cpu_wdata;
	end

	// Byte is captured on the first strobe so a late host write cannot tear it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_cnt_r <= 3'h0;
			tx_cur_r <= FES_REG_RESET;
		end
		else if (tx_link_strobe)
		begin
			tx_cnt_r <= tx_cnt_r + 3'h1;
			if (tx_cnt_r == 3'h0)
				tx_cur_r <= tx_byte_r;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_read(logic [7:0] a);
		cpu_rd && cpu_addr == a;
	endsequence
	sequence s_masks_quiet;
		(link_m_r == 8'h00 && frame_m_r == 8'h00) [*2];
	endsequence

	a_link_mask_back: assert property (s_read(FES_LINK_MASK_ADDR) |=> cpu_rdata_r == link_m_r)
		else $error("link mask read back wrong");
	a_frame_mask_back: assert property (s_read(FES_FRAME_MASK_ADDR) |=> cpu_rdata_r == frame_m_r)
		else $error("frame mask read back wrong");
	a_tx_byte_back: assert property (s_read(FES_TX_LINK_BYTE_ADDR) |=> cpu_rdata_r == tx_byte_r)
		else $error("tx link byte read back wrong");
	a_masked_int_idle: assert property (s_masks_quiet |-> int_n_r)
		else $error("interrupt with all masks clear");
	a_link_bit_order: assert property (tx_link_strobe |=> tx_link_bit_r == tx_cur_r[$past(tx_cnt_r)])
		else $error("tx link bit out of order");
	a_link_bit_hold: assert property (!tx_link_strobe |=> $stable(tx_link_bit_r))
		else $error("tx link bit moved without strobe");
	a_sa_bits_hold: assert property (!$past(tx_frame_tick) |=> $stable(tx_sa_bits_r))
		else $error("tx Sa bits moved without frame tick");
	a_ssm_valid_sticky: assert property (rx_ssm_valid_r |=> rx_ssm_valid_r)
		else $error("quality valid dropped");
	a_ssm_code_valid: assert property ($changed(rx_ssm_code_r) |-> rx_ssm_valid_r)
		else $error("quality code changed while not valid");
	a_reset_outputs: assert property ($rose(rst_n) |-> int_n_r && tx_sa_bits_r == 5'h1f)
		else $error("outputs not at reset values");
endmodule : fes_event_status_assertions

bind fes_event_status fes_event_status_assertions i_fes_event_status_assertions (
	.sys_clk, .rst_n, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata_r, .int_n_r,
	.tx_frame_tick, .tx_link_strobe, .tx_link_bit_r, .tx_sa_bits_r, .rx_ssm_code_r,
	.rx_ssm_valid_r);

// ===== fes_frame_counter.sv
`timescale 1ns/1ps
module fes_frame_counter
	import fes_pkg::*;
#(
	parameter int W = 5
)(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         tick,
	input  wire logic         resync,
	input  wire logic [W-1:0] frames,
	output logic      [W-1:0] idx_r,
	output logic              frame_start_r,
	output logic              mf_start_r
);

	logic [W-1:0] idx_nxt;

	always_comb
	begin
		if (resync || (idx_r == frames - W'(1)))
			idx_nxt = '0;
		else
			idx_nxt = idx_r + W'(1);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idx_r         <= '0;
			frame_start_r <= 1'b0;
			mf_start_r    <= 1'b0;
		end
		else
		begin
			frame_start_r <= tick;
			mf_start_r    <= tick && (idx_nxt == '0);
			if (tick)
				idx_r <= idx_nxt;
		end
	end

endmodule : fes_frame_counter

// ===== fes_line_model.sv
`timescale 1ns/1ps
module fes_line_model
	import fes_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       tx_link_bit_r,
	input  wire logic [4:0] tx_sa_bits_r,
	input  wire logic [7:0] ts16,
	input  wire logic [3:0] rx_code,
	input  wire logic [2:0] ssm_sa_sel,
	output logic            rx_frame_tick,
	output logic            tx_frame_tick,
	output logic      [7:0] rx_ts16_byte,
	output logic      [4:0] rx_sa_bits,
	output logic            rx_link_strobe,
	output logic            rx_link_bit,
	output logic            tx_link_strobe,
	output logic      [3:0] tx_seen
);
	// ------------------------------------------------------------
	// Remote framer: frame ticks, slot 16, Sa bits and link bits
	// ------------------------------------------------------------
	int idx = 0;

	initial
	begin
		{rx_frame_tick, tx_frame_tick, rx_link_strobe, rx_link_bit, tx_link_strobe} = 5'h00;
		rx_ts16_byte = 8'h00;
		rx_sa_bits   = 5'h1f;
		tx_seen      = 4'h0;
	end

	// Lines are inverted between ticks so stale data is never mistaken for valid
	task automatic frames(input int n);
		logic       sa;
		logic [4:0] sab;
		for (int f = 0; f < n; f++)
		begin
			sa  = rx_code[3 - ((idx >> 1) & 3)];
			sab = {5{~sa}};
			if (idx % 2 == 1)
				sab[ssm_sa_sel] = sa;
			@(posedge sys_clk);
			rx_frame_tick <= 1'b1;
			tx_frame_tick <= 1'b1;
			rx_ts16_byte  <= ts16;
			rx_sa_bits    <= sab;
			idx = (idx + 1) % 16;
			@(posedge sys_clk);
			rx_frame_tick <= 1'b0;
			tx_frame_tick <= 1'b0;
			rx_ts16_byte  <= ~ts16;
			rx_sa_bits    <= ~sab;
			@(posedge sys_clk);
			@(posedge sys_clk);
			if (idx % 2 == 1)
				tx_seen <= {tx_seen[2:0], tx_sa_bits_r[ssm_sa_sel]};
		end
	endtask : frames

	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			rx_link_strobe <= 1'b1;
			rx_link_bit    <= b[i];
			@(posedge sys_clk);
			rx_link_strobe <= 1'b0;
			rx_link_bit    <= ~b[i];
		end
	endtask : send_byte

	task automatic pull_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			tx_link_strobe <= 1'b1;
			@(posedge sys_clk);
			tx_link_strobe <= 1'b0;
			@(posedge sys_clk);
			b[i] = tx_link_bit_r;
		end
	endtask : pull_byte
endmodule : fes_line_model

// ===== fes_pkg.sv
// What this block does
// - Link event mask bits gate link interrupts
// - Frame mask bits 0-6 gate frame interrupts
// - E1 receive align frame event every 250us
// - E1 CRC4 multiframe event, free-run without CRC4
// - E1 receive multiframe event every 2ms
// - T1 multiframe events every 1.5ms/3ms
// - E1 transmit align frame event every 250us
// - E1 transmit multiframe event every 2ms
// - Slot 16 all zeros over multiframe
// - Slot 16 under three zeros per 16 frames
// - Transmit link byte sent bit 0 first
// - D4 Fs pattern taken from link byte
// - Sa access on CRC4 or double-frame boundaries
// - Quality message in one selectable Sa bit
// - Quality message MSB first, two per multiframe
// - Quality valid after three alike sub-multiframes
// - Quality message code values
// - Eight consecutive ones raise link abort
// - Thirty bits without abort raise code clear
// - Transmit clock idle 15 periods raises loss
// - New valid code raises code change event
package fes_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FES_LINK_STATUS_ADDR  = 8'h18;
	localparam logic [7:0] FES_LINK_MASK_ADDR    = 8'h19;
	localparam logic [7:0] FES_FRAME_STATUS_ADDR = 8'h1a;
	localparam logic [7:0] FES_FRAME_MASK_ADDR   = 8'h1b;
	localparam logic [7:0] FES_RX_LINK_BYTE_ADDR = 8'h50;
	localparam logic [7:0] FES_TX_LINK_BYTE_ADDR = 8'h51;
	localparam logic [7:0] FES_MATCH1_ADDR       = 8'h52;
	localparam logic [7:0] FES_MATCH2_ADDR       = 8'h53;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] FES_REG_RESET  = 8'h00;
	localparam logic [5:0] FES_CODE_RESET = 6'h3f;

	// ------------------------------------------------------------
	// Link status bit positions
	// ------------------------------------------------------------
	localparam int FES_B_CODE_CHANGE = 0;
	localparam int FES_B_MATCH       = 1;
	localparam int FES_B_TX_EMPTY    = 2;
	localparam int FES_B_RX_FULL     = 3;
	localparam int FES_B_ABORT       = 4;
	localparam int FES_B_CODE_CLEAR  = 5;
	localparam int FES_B_CLK_LOSS    = 6;
	localparam int FES_B_ALARM_CI    = 7;

	// ------------------------------------------------------------
	// Frame status bit positions
	// ------------------------------------------------------------
	localparam int FES_B_RX_ALIGN = 0;
	localparam int FES_B_RX_CRCMF = 1;
	localparam int FES_B_RX_MF    = 2;
	localparam int FES_B_TX_ALIGN = 3;
	localparam int FES_B_TX_MF    = 4;
	localparam int FES_B_SIG_ZERO = 5;
	localparam int FES_B_SIG_ONES = 6;

	// ------------------------------------------------------------
	// Framing counts (frames of 125us)
	// ------------------------------------------------------------
	localparam logic [4:0] FES_E1_MF_FRAMES  = 5'd16;
	localparam logic [4:0] FES_D4_MF_FRAMES  = 5'd12;
	localparam logic [4:0] FES_ESF_MF_FRAMES = 5'd24;
	localparam logic [3:0] FES_SUBMF_LAST_A  = 4'd7;
	localparam logic [3:0] FES_SUBMF_LAST_B  = 4'd15;
	localparam logic [3:0] FES_SIG_ZERO_MIN  = 4'd3;

	// ------------------------------------------------------------
	// Link bit counts and quality alike sub-multiframe count
	// ------------------------------------------------------------
	localparam logic [3:0] FES_ABORT_ONES   = 4'd8;
	localparam logic [4:0] FES_CLEAR_BITS   = 5'd30;
	localparam logic [1:0] FES_SSM_ALIKE    = 2'd3;

	// ------------------------------------------------------------
	// Transmit clock loss timing
	// ------------------------------------------------------------
	localparam int         FES_CLK_NS           = 5;
	localparam int         FES_SCALED_PERIOD_NS = 500;
	localparam int         FES_SCALED_TICKS     =
		(FES_SCALED_PERIOD_NS + FES_CLK_NS - 1) / FES_CLK_NS;
	localparam logic [3:0] FES_LOSS_PERIODS     = 4'd15;

	// ------------------------------------------------------------
	// Quality message codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		FES_SSM_UNKNOWN = 4'h0,
		FES_SSM_PRS     = 4'h2,
		FES_SSM_SSU_A   = 4'h4,
		FES_SSM_SSU_B   = 4'h8,
		FES_SSM_SETS    = 4'hb,
		FES_SSM_DNU     = 4'hf
	} fes_ssm_t;

endpackage : fes_pkg

// ===== test_fes_event_status.sv
`timescale 1ns/1ps
module test_fes_event_status
	import fes_pkg::*;
;
	logic       sys_clk, rst_n, cpu_wr, cpu_rd, int_n_r, e1_mode, esf_mode, crc4_en, clk_run;
	logic       rx_frame_tick, tx_frame_tick, rx_crc_mf_sync, rx_link_strobe, rx_link_bit;
	logic       tx_link_strobe, rx_alarm_ci_detect, tx_clk_pin, tx_link_bit_r, rx_ssm_valid_r;
	logic [2:0] ssm_sa_sel;
	logic [3:0] tx_ssm_code, rx_ssm_code_r, rx_code, tx_seen;
	logic [4:0] rx_sa_bits, tx_sa_bits_r;
	logic [7:0] cpu_addr, cpu_wdata, cpu_rdata_r, rx_ts16_byte, ts16, st, d;
	int         mismatches = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	fes_ssm_t   codes [6] = '{FES_SSM_UNKNOWN, FES_SSM_PRS, FES_SSM_SSU_A,
		FES_SSM_SSU_B, FES_SSM_SETS, FES_SSM_DNU};
	logic [7:0] ts_tab [6] = '{8'h00, 8'hff, 8'h01, 8'h7f, 8'h80, 8'h7f};
	logic [7:0] rx_seq [6] = '{8'hff, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};

	fes_event_status #(.SCALED_TICKS(4)) i_fes_event_status (
		.sys_clk, .rst_n, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata_r, .int_n_r,
		.e1_mode, .esf_mode, .crc4_en, .ssm_sa_sel, .tx_ssm_code, .rx_frame_tick,
		.rx_crc_mf_sync, .rx_ts16_byte, .rx_sa_bits, .tx_frame_tick, .rx_link_strobe,
		.rx_link_bit, .tx_link_strobe, .rx_alarm_ci_detect, .tx_clk_pin, .tx_link_bit_r,
		.tx_sa_bits_r, .rx_ssm_code_r, .rx_ssm_valid_r);

	fes_line_model i_fes_line_model (
		.sys_clk, .tx_link_bit_r, .tx_sa_bits_r, .ts16, .rx_code, .ssm_sa_sel,
		.rx_frame_tick, .tx_frame_tick, .rx_ts16_byte, .rx_sa_bits, .rx_link_strobe,
		.rx_link_bit, .tx_link_strobe, .tx_seen);

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// Pin toggles every fourth cycle so the three-stage filter sees it settle
	always @(posedge sys_clk)
		if (clk_run && (cycles % 4 == 0))
			tx_clk_pin <= ~tx_clk_pin;

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		cpu_addr  <= a;
		cpu_wdata <= v;
		cpu_wr    <= 1'b1;
		@(posedge sys_clk);
		cpu_wr    <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_rd   <= 1'b1;
		@(posedge sys_clk);
		cpu_rd   <= 1'b0;
		@(posedge sys_clk);
		check(cpu_rdata_r, exp);
	endtask : rd_chk

	task automatic int_chk(input logic exp);
		repeat (2) @(posedge sys_clk);
		check({7'h00, int_n_r}, {7'h00, exp});
	endtask : int_chk

	initial
	begin
		{cpu_addr, cpu_wdata, ts16} = 24'h00_0000;
		{cpu_wr, cpu_rd, e1_mode, esf_mode, rx_alarm_ci_detect, tx_clk_pin} = 6'h00;
		{crc4_en, rx_crc_mf_sync} = 2'h0;
		{ssm_sa_sel, tx_ssm_code, rx_code} = 11'h000;
		clk_run = 1'b1;
		rst_n = 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd_chk(FES_FRAME_STATUS_ADDR, FES_REG_RESET);
		rd_chk(FES_FRAME_MASK_ADDR, FES_REG_RESET);
		rd_chk(FES_TX_LINK_BYTE_ADDR, FES_REG_RESET);
		rd_chk(FES_LINK_MASK_ADDR, FES_REG_RESET);
		rd_chk(8'h7e, 8'h00);
		e1_mode <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			ts16        <= ts_tab[i];
			rx_code     <= codes[i];
			tx_ssm_code <= codes[5 - i];
			ssm_sa_sel  <= 3'(i % 5);
			wr(FES_FRAME_STATUS_ADDR, 8'hff);
			rd_chk(FES_FRAME_STATUS_ADDR, 8'h00);
			i_fes_line_model.frames(32);
			st = 8'h1f | ((ts_tab[i] == 8'h00) ? 8'h20 : 8'h00);
			st = st | ((ts_tab[i] == 8'hff) ? 8'h40 : 8'h00);
			rd_chk(FES_FRAME_STATUS_ADDR, st);
			wr(FES_FRAME_MASK_ADDR, 8'h01 << i);
			int_chk(~st[i]);
			wr(FES_FRAME_MASK_ADDR, 8'h00);
			check({4'h0, rx_ssm_code_r}, {4'h0, codes[i]});
			check({4'h0, tx_seen}, {4'h0, codes[5 - i]});
		end
		check({7'h00, rx_ssm_valid_r}, 8'h01);
		rd_chk(FES_LINK_STATUS_ADDR, 8'h00);
		e1_mode <= 1'b0;
		wr(FES_MATCH1_ADDR, 8'h5a);
		wr(FES_TX_LINK_BYTE_ADDR, 8'hb4);
		rd_chk(FES_TX_LINK_BYTE_ADDR, 8'hb4);
		i_fes_line_model.pull_byte(d);
		check(d, 8'hb4);
		i_fes_line_model.send_byte(8'h5a);
		rd_chk(FES_RX_LINK_BYTE_ADDR, 8'h5a);
		for (int k = 0; k < 6; k++)
			i_fes_line_model.send_byte(rx_seq[k]);
		@(posedge sys_clk);
		rx_alarm_ci_detect <= 1'b1;
		@(posedge sys_clk);
		rx_alarm_ci_detect <= 1'b0;
		clk_run <= 1'b0;
		repeat (120) @(posedge sys_clk);
		rd_chk(FES_LINK_STATUS_ADDR, 8'hff);
		wr(FES_LINK_MASK_ADDR, 8'h40);
		int_chk(1'b0);
		wr(FES_LINK_MASK_ADDR, 8'h00);
		int_chk(1'b1);
		for (int j = 0; j < 3; j++)
		begin
			esf_mode <= (j > 0);
			wr(FES_FRAME_STATUS_ADDR, 8'hff);
			i_fes_line_model.frames(12);
			rd_chk(FES_FRAME_STATUS_ADDR, (j == 1) ? 8'h00 : 8'h14);
		end
		wrap_up();
	end
endmodule : test_fes_event_status
